// File: panel_ctrl_port.sv
`timescale 1ns/1ns
`include "host_port_map.svh"
// Summary of operation
// - Strobes ignored while chip select high
// - Select line marks command or data
// - Intel mode: low write strobe writes
// - Intel mode: low read strobe drives data
// - Motorola mode: enable rising edge latches
// - Motorola mode: direction high read, low write
// - External reset returns controller to reset
// - Host holds select low one cycle
// - Host holds select high one cycle
// - First read valid after five cycles
// - Sleep-in command drives power output low unless GPIO config has claimed it
// - Sleep-out command drives power output high unless GPIO config has claimed it
module panel_ctrl_port import host_port_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Mode: 1 selects Motorola style
  input wire logic motorola_strobe_mode,
  // Link
  host_port_if.dev bus,
  // User side
  output logic wr_valid,
  output logic wr_is_cmd,
  output word_t wr_word,
  output logic rd_start,
  output logic rd_is_cmd,
  input wire word_t rd_word,
  output logic panel_power_output
);
  // ------------------------------
  // Pin synchronisers
  // ------------------------------
  logic [3:0] s1_r, s2_r, s3_r;
  word_t d1_r, d2_r;
  logic rs1_r, rs2_r;
  always_ff @(posedge clk) begin
    s1_r <= {bus.ctl_reset_b, bus.cs_b, bus.wr_b, bus.rd_b};
    s2_r <= s1_r;
    s3_r <= s2_r;
    d1_r <= bus.host_data_bus;
    d2_r <= d1_r;
    rs1_r <= bus.cmd_data_select;
    rs2_r <= rs1_r;
  end
  wire cs_n = s2_r[2];
  wire wr_n = s2_r[1];
  wire rd_n = s2_r[0];
  wire wr_p = s3_r[1];
  wire rd_p = s3_r[0];
  wire rst_all = !rst_b || !s2_r[3];
  // ------------------------------
  // Strobe decode
  // ------------------------------
  wire sel = !cs_n;
  wire i80_wr = !motorola_strobe_mode && sel && wr_n && !wr_p;
  wire i80_rd = !motorola_strobe_mode && sel && !rd_n && rd_p;
  // Enable rising edge latches a write; enable falling edge with direction high starts a read
  wire m68_edge = motorola_strobe_mode && sel && wr_n && !wr_p;
  wire m68_wr = m68_edge && !rd_n;
  wire m68_rd_go = motorola_strobe_mode && sel && rd_n && !wr_n && wr_p;
  wire wr_go = i80_wr || m68_wr;
  wire rd_go = i80_rd || m68_rd_go;
  wire rd_end = motorola_strobe_mode ? (cs_n || wr_n) : (cs_n || rd_n);
  wire is_cmd = !rs2_r;
  // ------------------------------
  // Command handling
  // ------------------------------
  logic gpio_claimed_r, conf_next_r;
  wire cmd_wr = wr_go && is_cmd;
  wire sleep_in = cmd_wr && d2_r[7:0] == `CMD_SLEEP_IN;
  wire sleep_out = cmd_wr && d2_r[7:0] == `CMD_SLEEP_OUT;
  always_ff @(posedge clk) begin
    if (rst_all) begin
      wr_valid <= 1'b0;
      wr_is_cmd <= 1'b0;
      wr_word <= 18'h00000;
      rd_start <= 1'b0;
      rd_is_cmd <= 1'b0;
      conf_next_r <= 1'b0;
      gpio_claimed_r <= 1'b0;
      panel_power_output <= `PWR_OUT_RESET;
    end else begin
      wr_valid <= wr_go;
      wr_is_cmd <= is_cmd;
      if (wr_go) begin
        wr_word <= d2_r;
      end
      rd_start <= rd_go;
      rd_is_cmd <= is_cmd;
      if (cmd_wr) begin
        conf_next_r <= d2_r[7:0] == `CMD_GPIO_CONF;
      end else if (wr_go && conf_next_r) begin
        // First parameter bit 0 hands the output to another use
        gpio_claimed_r <= d2_r[0];
        conf_next_r <= 1'b0;
      end
      if (sleep_in && !gpio_claimed_r) begin
        panel_power_output <= 1'b0;
      end else if (sleep_out && !gpio_claimed_r) begin
        panel_power_output <= 1'b1;
      end
    end
  end
  // ------------------------------
  // Read drive
  // ------------------------------
  // Drive the bus only for the read strobe so no fight with host writes
  always_ff @(posedge clk) begin
    if (rst_all) begin
      bus.dev_data_oe_b <= 1'b1;
      bus.dev_data_o <= 18'h00000;
    end else begin
      if (rd_start) begin
        bus.dev_data_oe_b <= 1'b0;
        bus.dev_data_o <= rd_word;
      end else if (rd_end) begin
        bus.dev_data_oe_b <= 1'b1;
      end
    end
  end
endmodule : panel_ctrl_port

// File: host_port_map.svh
`ifndef HOST_PORT_MAP_SVH
`define HOST_PORT_MAP_SVH
`define BUS_W 18
`define CMD_SLEEP_IN 8'h10
`define CMD_SLEEP_OUT 8'h11
`define CMD_GPIO_CONF 8'hb8
`define PWR_OUT_RESET 1'b0
`define REF_CLOCK_PERIOD_NS 4
`define SELECT_LOW_WIDTH_CYC 1
`define SELECT_HIGH_WIDTH_CYC 1
`define FIRST_READ_LATENCY_CYC 5
`define SEL_LOW_CNT (`SELECT_LOW_WIDTH_CYC)
`define SEL_HIGH_CNT (`SELECT_HIGH_WIDTH_CYC)
`define FIRST_READ_CNT (`FIRST_READ_LATENCY_CYC + 2)
`endif

// File: host_port_pkg.sv
package host_port_pkg;
  typedef logic [17:0] word_t;
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_LOW = 2'b01,
    HS_WAIT = 2'b11,
    HS_HIGH = 2'b10
  } hs_e;
endpackage : host_port_pkg

// File: host_port_if.sv
`timescale 1ns/1ns
interface host_port_if;
  logic cs_b;
  logic cmd_data_select;
  logic wr_b;
  logic rd_b;
  logic ctl_reset_b;
  logic [17:0] host_data_bus_o;
  logic host_data_bus_oe_b;
  logic [17:0] dev_data_o;
  logic dev_data_oe_b;
  // A released bus shows the inverse, so stale data cannot pass as valid
  wire [17:0] host_data_bus = !dev_data_oe_b ? dev_data_o :
                              !host_data_bus_oe_b ? host_data_bus_o :
                              ~host_data_bus_o;
  modport host (output cs_b, cmd_data_select, wr_b, rd_b, ctl_reset_b,
    output host_data_bus_o, host_data_bus_oe_b, input host_data_bus);
  modport dev (input cs_b, cmd_data_select, wr_b, rd_b, ctl_reset_b,
    input host_data_bus, output dev_data_o, dev_data_oe_b);
endinterface : host_port_if

// File: mcu_host_port.sv
`timescale 1ns/1ns
`include "host_port_map.svh"
module mcu_host_port import host_port_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Mode: 1 selects Motorola style
  input wire logic motorola_strobe_mode,
  // Link
  host_port_if.host bus,
  // User side
  input wire logic req_valid,
  input wire logic req_read,
  input wire logic req_is_cmd,
  input wire word_t req_word,
  input wire logic ctl_reset_req,
  output logic req_ready,
  output logic rd_valid,
  output word_t rd_data
);
  hs_e st_r, st_nxt;
  logic [7:0] cnt_r;
  logic rd_r;
  word_t rd_sync1_r, rd_sync2_r;
  wire idle = st_r == HS_IDLE;
  wire cnt_done = cnt_r == 8'h00;
  wire take = idle && req_valid;
  assign req_ready = idle;
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      HS_IDLE: if (req_valid) st_nxt = HS_LOW;
      HS_LOW: if (cnt_done) st_nxt = HS_WAIT;
      HS_WAIT: if (cnt_done) st_nxt = HS_HIGH;
      HS_HIGH: if (cnt_done) st_nxt = HS_IDLE;
      default: st_nxt = HS_IDLE;
    endcase
  end
  // ------------------------------
  // Strobe sequencer
  // ------------------------------
  // Low phase covers the device synchroniser and first-read latency
  always_ff @(posedge clk) begin
    rd_sync1_r <= bus.host_data_bus;
    rd_sync2_r <= rd_sync1_r;
    if (!rst_b) begin
      st_r <= HS_IDLE;
      cnt_r <= 8'h00;
      rd_r <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= 18'h00000;
      bus.cs_b <= 1'b1;
      bus.wr_b <= 1'b1;
      bus.rd_b <= 1'b1;
      bus.cmd_data_select <= 1'b1;
      bus.ctl_reset_b <= 1'b0;
      bus.host_data_bus_o <= 18'h00000;
      bus.host_data_bus_oe_b <= 1'b1;
    end else begin
      st_r <= st_nxt;
      rd_valid <= 1'b0;
      bus.ctl_reset_b <= !ctl_reset_req;
      cnt_r <= cnt_done ? 8'h00 : cnt_r - 8'h01;
      if (take) begin
        rd_r <= req_read;
        bus.cs_b <= 1'b0;
        bus.cmd_data_select <= !req_is_cmd;
        bus.host_data_bus_o <= req_word;
        bus.host_data_bus_oe_b <= req_read;
        // Motorola: direction high reads, E drops to frame the access
        bus.rd_b <= motorola_strobe_mode ? req_read : !req_read;
        bus.wr_b <= motorola_strobe_mode ? 1'b0 : req_read;
        if (!motorola_strobe_mode && req_read) begin
          bus.rd_b <= 1'b0;
        end
        cnt_r <= 8'(`SEL_LOW_CNT + 3 + (req_read ? `FIRST_READ_CNT : 0));
      end else if (st_r == HS_LOW && cnt_done) begin
        cnt_r <= 8'h02;
        if (rd_r) begin
          rd_valid <= 1'b1;
          rd_data <= rd_sync2_r;
        end
        bus.wr_b <= 1'b1;
        if (!motorola_strobe_mode) bus.rd_b <= 1'b1;
      end else if (st_r == HS_WAIT && cnt_done) begin
        bus.cs_b <= 1'b1;
        bus.host_data_bus_oe_b <= 1'b1;
        cnt_r <= 8'(`SEL_HIGH_CNT + 3);
      end
    end
  end
endmodule : mcu_host_port

// File: host_port_properties.sv
`timescale 1ns/1ns
module host_port_properties (
  // Clock and reset
  input logic clk,
  input logic rst_b,
  // Link
  input logic cs_b,
  input logic wr_b,
  input logic rd_b,
  input logic ctl_reset_b,
  input logic [17:0] host_data_bus_o,
  input logic host_data_bus_oe_b,
  input logic dev_data_oe_b
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // ----
  // Link checks
  // ----
  sequence rd_begin;
    $fell(rd_b) && !cs_b && wr_b;
  endsequence
  a_read_wait: assert property (rd_begin |-> !rd_b [*5])
    else $error("read strobe too short");
  a_sel_low: assert property ($fell(cs_b) |=> !cs_b)
    else $error("select low too short");
  a_sel_high: assert property ($rose(cs_b) |=> cs_b)
    else $error("select high too short");
  // Sync delay lets the device drive briefly after deselect
  a_unsel_quiet: assert property (cs_b [*6] |-> dev_data_oe_b)
    else $error("device drives while unselected");
  a_no_contend: assert property (!dev_data_oe_b |-> host_data_bus_oe_b)
    else $error("both ends drive the bus");
  a_write_hold: assert property (!cs_b && !$past(cs_b) &&
    !host_data_bus_oe_b && !$past(host_data_bus_oe_b)
    |-> $stable(host_data_bus_o)) else $error("write data moved");
  a_host_reset: assert property (disable iff (1'b0) !rst_b |=>
    cs_b && wr_b && rd_b && !ctl_reset_b && host_data_bus_oe_b)
    else $error("host not idle in reset");
  a_dev_reset: assert property (!ctl_reset_b [*5] |-> dev_data_oe_b)
    else $error("device drives in reset");
endmodule : host_port_properties

// File: tb_top.sv
`timescale 1ns/1ns
module tb_top import host_port_pkg::*; ();
  logic clk, rst_b, mode, req_valid, req_read, req_is_cmd, ctl_reset_req;
  logic req_ready, rd_valid, wr_valid, wr_is_cmd, pwr;
  logic rd_start, rd_is_cmd;
  word_t req_word, rd_word, rd_data, wr_word;
  int mismatches = 0;
  int n_tests = 0;
  int cyc = 0;
  host_port_if bus ();
  mcu_host_port u_mcu_host_port (.clk(clk), .rst_b(rst_b),
    .motorola_strobe_mode(mode), .bus(bus), .req_valid(req_valid),
    .req_read(req_read), .req_is_cmd(req_is_cmd), .req_word(req_word),
    .ctl_reset_req(ctl_reset_req), .req_ready(req_ready),
    .rd_valid(rd_valid), .rd_data(rd_data));
  panel_ctrl_port u_panel_ctrl_port (.clk(clk), .rst_b(rst_b),
    .motorola_strobe_mode(mode), .bus(bus), .wr_valid(wr_valid),
    .wr_is_cmd(wr_is_cmd), .wr_word(wr_word), .rd_start(rd_start),
    .rd_is_cmd(rd_is_cmd), .rd_word(rd_word), .panel_power_output(pwr));
  host_port_properties u_host_port_properties (.clk(clk), .rst_b(rst_b),
    .cs_b(bus.cs_b), .wr_b(bus.wr_b), .rd_b(bus.rd_b),
    .ctl_reset_b(bus.ctl_reset_b), .host_data_bus_o(bus.host_data_bus_o),
    .host_data_bus_oe_b(bus.host_data_bus_oe_b),
    .dev_data_oe_b(bus.dev_data_oe_b));
  // ----
  // Tasks
  // ----
  task chk(input word_t got, input word_t exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task send(input logic rd, input logic cmd, input word_t w);
    @(posedge clk);
    req_valid <= 1'b1;
    req_read <= rd;
    req_is_cmd <= cmd;
    req_word <= w;
    do @(posedge clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
  endtask : send
  task wr(input logic cmd, input word_t w);
    send(1'b0, cmd, w);
    do @(posedge clk); while (wr_valid !== 1'b1);
    chk(wr_word, w);
    chk({17'h0, wr_is_cmd}, {17'h0, cmd});
  endtask : wr
  task rd(input word_t w);
    rd_word <= w;
    send(1'b1, 1'b0, w);
    do @(posedge clk); while (rd_start !== 1'b1);
    chk({17'h0, rd_is_cmd}, 18'h00000);
    do @(posedge clk); while (rd_valid !== 1'b1);
    chk(rd_data, w);
  endtask : rd
  task pw(input logic e);
    repeat (3) @(posedge clk);
    chk({17'h0, pwr}, {17'h0, e});
  endtask : pw
  task stop_test;
    if (mismatches == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  // ----
  // Sequence
  // ----
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      mismatches++;
      stop_test;
    end
  end
  initial begin
    rst_b = 1'b0;
    mode = 1'b0;
    {req_valid, req_read, req_is_cmd, ctl_reset_req} = 4'h0;
    req_word = '0;
    rd_word = '0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
    for (int m = 0; m < 2; m++) begin
      mode <= m[0];
      repeat (4) @(posedge clk);
      wr(1'b1, 18'h3ffff);
      wr(1'b0, 18'h2aaaa);
      rd(18'h15555);
      rd(18'h0c3c3);
    end
    wr(1'b1, 18'h00011);
    pw(1'b1);
    wr(1'b1, 18'h00010);
    pw(1'b0);
    // Claim the power output away, so sleep-exit must be ignored
    wr(1'b1, 18'h000b8);
    wr(1'b0, 18'h00001);
    wr(1'b1, 18'h00011);
    pw(1'b0);
    ctl_reset_req <= 1'b1;
    repeat (6) @(posedge clk);
    ctl_reset_req <= 1'b0;
    repeat (10) @(posedge clk);
    wr(1'b1, 18'h00011);
    pw(1'b1);
    stop_test;
  end
endmodule : tb_top
